// ==== hw/csl_pkg.sv ====
// Constants, state types and helpers shared by the status indicator sequencer.
// Assumes a single 100 MHz system clock and a synchronous active-high reset.
//
// What this block does
// - No network, configuration loaded: power on, error off, ready blinks, bus-active off.
// - No network, backplane fault or load failure: error on, ready and bus-active off.
// - Network without master: bus-active blinks only if another node is active, address unique.
// - Bad address, duplicate address or bad rate: error on, ready and bus-active off.
// - Network, no master, load failure: error on, ready blinks, bus-active blinks only if another node is active.
// - Load failure with master: error on, ready blinks, bus-active on, self-reset after 30 s.
// - Bus-active stays on while a master connection exists, unless configuration mode is selected, the address is bad or a module failure is shown.
// - Normal operation with master: power, ready and bus-active on, error off.
// - Backplane error with master: error on, ready off, bus-active on.
// - Backplane error with master: self-reset once 30 s have elapsed.
// - Module failure with master: only error and power for 1 s, then reset and restart.
// - Restart after size change with failed load: error on, ready blinks, bus-active on.
// - Restart after size change with modules connected: error off, ready and bus-active on.
// - Connection timer expiry with master: error and ready blink, bus-active on, I/O zeroed.
// - Selector 0 to 63 selects network mode and is the node address.
// - Selector 90 to 92 selects configuration mode instead.

package csl_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam logic [63:0] CSL_CLK_HZ         = 64'h0000_0000_05f5_e100; // 100 MHz
   localparam logic [63:0] CSL_BLINK_HALF_MS  = 64'h0000_0000_0000_01f4; // 500 ms
   localparam logic [63:0] CSL_SELF_RESET_S   = 64'h0000_0000_0000_001e; // 30 s
   localparam logic [63:0] CSL_MOD_ERR_S      = 64'h0000_0000_0000_0001; // 1 s
   localparam logic [63:0] CSL_MS_PER_S       = 64'h0000_0000_0000_03e8;
   localparam logic [31:0] CSL_BLINK_HALF_CYC = 32'(CSL_BLINK_HALF_MS * CSL_CLK_HZ / CSL_MS_PER_S);
   localparam logic [31:0] CSL_SELF_RESET_CYC = 32'(CSL_SELF_RESET_S * CSL_CLK_HZ);
   localparam logic [31:0] CSL_MOD_ERR_CYC    = 32'(CSL_MOD_ERR_S * CSL_CLK_HZ);

   // ****************************************************************
   // Address selector ranges
   // ****************************************************************
   localparam logic [6:0] CSL_NODE_MIN = 7'h00; // 0
   localparam logic [6:0] CSL_NODE_MAX = 7'h3f; // 63
   localparam logic [6:0] CSL_CFG_MIN  = 7'h5a; // 90
   localparam logic [6:0] CSL_CFG_MAX  = 7'h5c; // 92

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic {CSL_ST_RUN, CSL_ST_MODFAIL} csl_state_e;

   typedef struct packed {
      csl_state_e  st;
      logic [31:0] tmr;
      logic        pwr;
      logic        err;
      logic        rdy;
      logic        bact;
      logic        srst;
      logic        ioz;
      logic        cfgm;
      logic [5:0]  addr;
      logic [31:0] tf_len;
      logic [31:0] mf_len;
   } csl_top_s;

   typedef struct packed {
      logic [31:0] cnt;
      logic        phase;
   } csl_blink_s;

   localparam csl_top_s   CSL_TOP_RST   = '0;
   localparam csl_blink_s CSL_BLINK_RST = '0;

   // Inclusive range test on the selector, used for both modes
   function automatic logic csl_in_range(input logic [6:0] v, input logic [6:0] lo, input logic [6:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction

endpackage

// ==== hw/csl_blink.sv ====
// Common blink phase generator for all blinking indicators.
// Assumes one clock; the phase toggles every HALF_CYC cycles from reset.
`timescale 1ns/10ps

module csl_blink
   import csl_pkg::*;
#(
   parameter logic [31:0] HALF_CYC = CSL_BLINK_HALF_CYC
)(
   input  wire logic clk_i,
   input  wire logic srst_i,
   output logic      phase_o
);

   csl_blink_s q;
   csl_blink_s d;

   // ****************************************************************
   // Phase counter
   // ****************************************************************
   // one half of the blink period
   always_comb begin
      d = q;
      if (q.cnt >= HALF_CYC - 32'h1) begin
         d.cnt   = '0;
         d.phase = ~q.phase;
      end else begin
         d.cnt = q.cnt + 32'h1;
      end
   end

   // Registered state
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         q <= CSL_BLINK_RST;
      end else begin
         q <= d;
      end
   end

   assign phase_o = q.phase;

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_blink_period: assert property (@(posedge clk_i) disable iff (srst_i)
      (q.cnt == HALF_CYC - 32'h1) |=> (phase_o != $past(phase_o)) && (q.cnt == 32'h0))
      else $error("blink phase did not toggle at period end");

endmodule

// ==== hw/csl_top.sv ====
// Status indicator sequencer of the fieldbus coupler: power, error, ready and bus-active.
// Assumes all status inputs are synchronous levels from the protocol engine and backplane
// controller; MOD_FAIL_I is sampled only in the run state. SELF_RST_O is a one-cycle restart request.
`timescale 1ns/10ps

module csl_top
   import csl_pkg::*;
#(
   parameter logic [31:0] BLINK_HALF_CYC = CSL_BLINK_HALF_CYC,
   parameter logic [31:0] SELF_RESET_CYC = CSL_SELF_RESET_CYC,
   parameter logic [31:0] MOD_ERR_CYC    = CSL_MOD_ERR_CYC
)(
   input  wire logic       CLK_I,
   input  wire logic       SRST_I,
   input  wire logic [6:0] ADDR_SEL_I,
   input  wire logic       RATE_OK_I,
   input  wire logic       ADDR_DUP_I,
   input  wire logic       NET_PRESENT_I,
   input  wire logic       NODE_ACTIVE_I,
   input  wire logic       MASTER_CONN_I,
   input  wire logic       CFG_DONE_I,
   input  wire logic       CFG_OK_I,
   input  wire logic       BP_FAULT_I,
   input  wire logic       MOD_FAIL_I,
   input  wire logic       IO_TMO_I,
   output logic            POWER_INDICATOR_O,
   output logic            ERROR_INDICATOR_O,
   output logic            READY_IND_O,
   output logic            BUSACT_IND_O,
   output logic            SELF_RST_O,
   output logic            IO_ZERO_O,
   output logic            CFG_MODE_O,
   output logic [5:0]      NODE_ADDR_O
);

   csl_top_s q;
   csl_top_s d;
   logic     bl;
   logic     cfg_mode;
   logic     node_ok;
   logic     addr_bad;
   logic     cfg_fail;
   logic     cfg_good;
   logic     master;
   logic     run;
   logic     timed_fault;
   logic     mod_go;

   // ****************************************************************
   // Blink source
   // ****************************************************************
   // shared period
   csl_blink #(
      .HALF_CYC (BLINK_HALF_CYC)
   ) u_blink (
      .clk_i   (CLK_I),
      .srst_i  (SRST_I),
      .phase_o (bl)
   );

   // ****************************************************************
   // Condition decode
   // ****************************************************************
   // Decoded conditions, shared by the next-state logic and the checks
   always_comb begin
      cfg_mode = csl_in_range(ADDR_SEL_I, CSL_CFG_MIN, CSL_CFG_MAX);
      node_ok  = csl_in_range(ADDR_SEL_I, CSL_NODE_MIN, CSL_NODE_MAX);
      addr_bad = !cfg_mode && (!node_ok || ADDR_DUP_I || !RATE_OK_I);
      cfg_fail = CFG_DONE_I && !CFG_OK_I;
      cfg_good = CFG_DONE_I && CFG_OK_I;
      master   = NET_PRESENT_I && MASTER_CONN_I;
      run      = (q.st == CSL_ST_RUN);
      // faults that end in a timed restart
      timed_fault = run && !cfg_mode && !addr_bad && master && !IO_TMO_I && (BP_FAULT_I || cfg_fail);
      mod_go   = run && MOD_FAIL_I && master && !cfg_mode && !addr_bad;
   end

   // ****************************************************************
   // Next state and indicator patterns
   // ****************************************************************
   // Outputs are computed for the next cycle so every port leaves a flip-flop
   always_comb begin
      d      = q;
      d.pwr  = 1'b1;
      d.srst = 1'b0;
      d.ioz  = 1'b0;
      d.err  = 1'b0;
      d.rdy  = 1'b0;
      d.bact = 1'b0;
      d.cfgm = cfg_mode;
      if (node_ok) begin
         d.addr = ADDR_SEL_I[5:0];
      end
      case (q.st)
         CSL_ST_RUN: begin
            if (mod_go) begin
               d.st  = CSL_ST_MODFAIL;
               d.tmr = '0;
               d.err = 1'b1;
            end else if (cfg_mode) begin
               // Configuration mode lamps: keep only power lit; error, ready and bus-active off
               d.tmr = '0;
            end else if (addr_bad) begin
               d.err = 1'b1;
               d.tmr = '0;
            end else if (!NET_PRESENT_I) begin
               d.tmr = '0;
               if (BP_FAULT_I || cfg_fail) begin
                  d.err = 1'b1;
               end else if (cfg_good) begin
                  d.rdy = bl;
               end
            end else if (master) begin
               d.bact = 1'b1;
               if (IO_TMO_I) begin
                  // timer expiry, inputs and outputs forced to zero
                  d.err = bl;
                  d.rdy = bl;
                  d.ioz = 1'b1;
               end else if (BP_FAULT_I) begin
                  d.err = 1'b1;
               end else if (cfg_fail) begin
                  d.err = 1'b1;
                  d.rdy = bl;
               end else if (cfg_good) begin
                  d.rdy = 1'b1;
               end
               // restart after the fault has held for the full wait
               if (timed_fault) begin
                  if (q.tmr >= SELF_RESET_CYC - 32'h1) begin
                     d.tmr  = '0;
                     d.srst = 1'b1;
                  end else begin
                     d.tmr = q.tmr + 32'h1;
                  end
               end else begin
                  d.tmr = '0;
               end
            end else begin
               // Network without master
               d.tmr = '0;
               if (BP_FAULT_I) begin
                  d.err = 1'b1;
               end else begin
                  // load failure still lets ready blink
                  d.err  = cfg_fail;
                  d.rdy  = CFG_DONE_I ? bl : 1'b0;
                  // needs a peer; uniqueness is covered by the address check
                  d.bact = NODE_ACTIVE_I ? bl : 1'b0;
               end
            end
         end
         CSL_ST_MODFAIL: begin
            // hold the error pattern, then request the restart
            d.err = 1'b1;
            if (q.tmr >= MOD_ERR_CYC - 32'h1) begin
               d.st   = CSL_ST_RUN;
               d.tmr  = '0;
               d.srst = 1'b1;
               d.err  = 1'b0;
            end else begin
               d.tmr = q.tmr + 32'h1;
            end
         end
         default: begin
            d.st  = CSL_ST_RUN;
            d.tmr = '0;
         end
      endcase
      // Check helpers: independent counts of fault and failure hold times
      if (q.srst || !timed_fault) begin
         d.tf_len = {31'h0, timed_fault};
      end else begin
         d.tf_len = q.tf_len + 32'h1;
      end
      if (q.st == CSL_ST_MODFAIL) begin
         d.mf_len = q.mf_len + 32'h1;
      end else begin
         d.mf_len = '0;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // Synchronous reset to constants only
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         q <= CSL_TOP_RST;
      end else begin
         q <= d;
      end
   end

   // Ports driven straight from the state register
   assign POWER_INDICATOR_O = q.pwr;
   assign ERROR_INDICATOR_O = q.err;
   assign READY_IND_O       = q.rdy;
   assign BUSACT_IND_O      = q.bact;
   assign SELF_RST_O        = q.srst;
   assign IO_ZERO_O         = q.ioz;
   assign CFG_MODE_O        = q.cfgm;
   assign NODE_ADDR_O       = q.addr;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SRST_I);

   // Common guard: running, not in configuration mode, no module failure starting
   sequence s_quiet;
      run && !mod_go && !cfg_mode;
   endsequence

   sequence s_mf_start;
      mod_go;
   endsequence

   sequence s_mf_lamps;
      ERROR_INDICATOR_O && POWER_INDICATOR_O && !READY_IND_O && !BUSACT_IND_O;
   endsequence

   a_power_lit: assert property (!SRST_I |=> POWER_INDICATOR_O)
      else $error("power indicator not lit");

   a_loaded_idle: assert property (s_quiet ##0 (!addr_bad && !NET_PRESENT_I && cfg_good && !BP_FAULT_I)
      |=> !ERROR_INDICATOR_O && !BUSACT_IND_O && (READY_IND_O == $past(bl)))
      else $error("loaded idle pattern wrong");

   a_backplane_idle: assert property (s_quiet ##0 (!addr_bad && !NET_PRESENT_I && BP_FAULT_I)
      |=> ERROR_INDICATOR_O && !READY_IND_O && !BUSACT_IND_O)
      else $error("idle fault pattern wrong");

   a_peer_blink: assert property (s_quiet ##0 (!addr_bad && NET_PRESENT_I && !MASTER_CONN_I && !BP_FAULT_I)
      |=> BUSACT_IND_O == ($past(NODE_ACTIVE_I) && $past(bl)))
      else $error("bus-active blink without peer");

   a_address_error: assert property (s_quiet ##0 addr_bad
      |=> ERROR_INDICATOR_O && !READY_IND_O && !BUSACT_IND_O)
      else $error("address error pattern wrong");

   a_master_busact: assert property (s_quiet ##0 (!addr_bad && master) |=> BUSACT_IND_O)
      else $error("bus-active off with master");

   a_normal_run: assert property (s_quiet ##0 (!addr_bad && master && cfg_good && !BP_FAULT_I && !IO_TMO_I)
      |=> !ERROR_INDICATOR_O && READY_IND_O && BUSACT_IND_O)
      else $error("normal pattern wrong");

   a_conn_timeout: assert property (s_quiet ##0 (!addr_bad && master && IO_TMO_I)
      |=> IO_ZERO_O && (ERROR_INDICATOR_O == $past(bl)) && (READY_IND_O == $past(bl)))
      else $error("timeout pattern wrong");

   a_fault_wait: assert property (SELF_RST_O && ($past(q.st) == CSL_ST_RUN)
      |-> q.tf_len == SELF_RESET_CYC)
      else $error("timed restart at wrong time");

   a_mf_lamps: assert property (s_mf_start |=> s_mf_lamps ##1 (s_mf_lamps or SELF_RST_O))
      else $error("module failure lamps wrong");

   a_mf_length: assert property (SELF_RST_O && ($past(q.st) == CSL_ST_MODFAIL)
      |-> q.mf_len == MOD_ERR_CYC)
      else $error("module failure hold time wrong");

   a_node_addr: assert property (node_ok |=> NODE_ADDR_O == $past(ADDR_SEL_I[5:0]) && !CFG_MODE_O)
      else $error("node address not taken");

   a_cfg_mode: assert property (cfg_mode |=> CFG_MODE_O)
      else $error("configuration mode not flagged");

   a_net_load_fail: assert property (s_quiet ##0 (!addr_bad && NET_PRESENT_I && !master && !BP_FAULT_I && cfg_fail)
      |=> ERROR_INDICATOR_O && (READY_IND_O == $past(bl)))
      else $error("network load failure pattern wrong");

   a_master_load_fail: assert property (s_quiet ##0 (!addr_bad && master && !IO_TMO_I && !BP_FAULT_I && cfg_fail)
      |=> ERROR_INDICATOR_O && BUSACT_IND_O && (READY_IND_O == $past(bl)))
      else $error("master load failure pattern wrong");

   a_master_bp_fault: assert property (s_quiet ##0 (!addr_bad && master && !IO_TMO_I && BP_FAULT_I)
      |=> ERROR_INDICATOR_O && !READY_IND_O && BUSACT_IND_O)
      else $error("backplane fault with master pattern wrong");

   a_cfg_power_only: assert property (run && !mod_go && cfg_mode
      |=> POWER_INDICATOR_O && !ERROR_INDICATOR_O && !READY_IND_O && !BUSACT_IND_O)
      else $error("configuration mode lamps wrong");

   a_io_zero_cause: assert property (IO_ZERO_O
      |-> $past(IO_TMO_I) && $past(master))
      else $error("inputs and outputs zeroed without timeout");

   a_mf_dark: assert property (q.st == CSL_ST_MODFAIL
      |=> POWER_INDICATOR_O && !READY_IND_O && !BUSACT_IND_O)
      else $error("ready or bus-active lit during module failure");

endmodule

// ==== bench/csl_far_model.sv ====
// Far-side model: status sources of the master scanner, the network and the backplane modules.
// Assumes the bench states the wanted levels; every line changes at the falling clock edge.
`timescale 1ns/10ps

module csl_far_model (
   input  wire logic        clk_i,
   input  wire logic [15:0] want_i,
   input  wire logic        fail_req_i,
   output logic      [15:0] lines_o,
   output logic             mod_fail_o
);
   logic req_q;

   // Quiet lines at time zero, so the design never sees an unknown status
   initial begin
      lines_o    = 16'h0000;
      mod_fail_o = 1'b0;
      req_q      = 1'b0;
   end

   // A module failure is reported once per request, one cycle long, as the backplane does
   always @(negedge clk_i) begin
      lines_o    <= want_i;
      mod_fail_o <= fail_req_i && !req_q;
      req_q      <= fail_req_i;
   end
endmodule

// ==== bench/tb_csl_top.sv ====
// Self-checking bench of the status indicator sequencer: corner cases, random mixes, timed restarts.
// Assumes shortened timing parameters; lamps are classed as off, on or blinking over a window.
`timescale 1ns/10ps

module tb_csl_top;
   localparam logic [31:0] HALF = 32'h0000_0004;
   localparam logic [31:0] SRC  = 32'h0000_0014;
   localparam logic [31:0] MEC  = 32'h0000_000a;
   localparam logic [1:0]  OFF  = 2'h0;
   localparam logic [1:0]  ON   = 2'h1;
   localparam logic [1:0]  BL   = 2'h2;

   // Status word: [15:9] selector, rate ok, duplicate, net, node, master, done, ok, bp fault, io timeout
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic [15:0] want = 16'h0b0c;
   logic        fail_req = 1'b0;
   logic [15:0] lines;
   logic        mod_fail;
   logic        pw, er, rd, ba, srst_req, ioz, cfgm;
   logic [5:0]  node;
   logic [15:0] seed = 16'h0038;
   logic [5:0]  exp_addr = 6'h00;
   logic [15:0] fault [2] = '{16'h0b58, 16'h0b5e};
   logic [15:0] corner [18] = '{16'h0b0c, 16'h0b0e, 16'h0b08, 16'h0b6c, 16'h0b4c, 16'h814c,
                                16'h0bcc, 16'h0a4c, 16'h7f0c, 16'hb30c, 16'hb50c, 16'hb90c,
                                16'hbb0c, 16'h0b68, 16'h0b58, 16'h0b5c, 16'h0b5d, 16'h0b5e};
   int          idx;
   int          n_mismatch = 0;
   int          checks_done = 0;

   always #5 clk = ~clk;

   csl_far_model i_csl_far_model (
      .clk_i      (clk),
      .want_i     (want),
      .fail_req_i (fail_req),
      .lines_o    (lines),
      .mod_fail_o (mod_fail)
   );

   csl_top #(
      .BLINK_HALF_CYC (HALF),
      .SELF_RESET_CYC (SRC),
      .MOD_ERR_CYC    (MEC)
   ) i_csl_top (
      .CLK_I             (clk),
      .SRST_I            (srst),
      .ADDR_SEL_I        (lines[15:9]),
      .RATE_OK_I         (lines[8]),
      .ADDR_DUP_I        (lines[7]),
      .NET_PRESENT_I     (lines[6]),
      .NODE_ACTIVE_I     (lines[5]),
      .MASTER_CONN_I     (lines[4]),
      .CFG_DONE_I        (lines[3]),
      .CFG_OK_I          (lines[2]),
      .BP_FAULT_I        (lines[1]),
      .MOD_FAIL_I        (mod_fail),
      .IO_TMO_I          (lines[0]),
      .POWER_INDICATOR_O (pw),
      .ERROR_INDICATOR_O (er),
      .READY_IND_O       (rd),
      .BUSACT_IND_O      (ba),
      .SELF_RST_O        (srst_req),
      .IO_ZERO_O         (ioz),
      .CFG_MODE_O        (cfgm),
      .NODE_ADDR_O       (node)
   );

   // ****************************************************************
   // Expectations and helpers
   // ****************************************************************
   // Pattern {io zero, power, error, ready, bus-active}; first matching condition wins
   function automatic logic [8:0] exp_pat(input logic [15:0] v);
      logic cfail;
      cfail = v[3] && !v[2];
      if (v[15:9] inside {[7'h5a:7'h5c]}) return {1'b0, ON, OFF, OFF, OFF};
      if (v[15:9] > 7'h3f || v[7] || !v[8]) return {1'b0, ON, ON, OFF, OFF};
      if (!v[6]) return (v[1] || cfail) ? {1'b0, ON, ON, OFF, OFF} : {1'b0, ON, OFF, BL, OFF};
      if (v[4]) begin
         if (v[0]) return {1'b1, ON, BL, BL, ON};
         if (v[1]) return {1'b0, ON, ON, OFF, ON};
         return {1'b0, ON, cfail ? ON : OFF, cfail ? BL : ON, ON};
      end
      if (v[1]) return {1'b0, ON, ON, OFF, OFF};
      return {1'b0, ON, cfail ? ON : OFF, v[3] ? BL : OFF, v[5] ? BL : OFF};
   endfunction

   function automatic logic [15:0] nxt(input logic [15:0] s);
      for (int k = 0; k < 16; k++)
         s = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
      return s;
   endfunction

   // Done flag is left open only for network without master, where the decode reads it
   function automatic logic [15:0] mix(input logic [15:0] r);
      logic [6:0] sel;
      logic       net;
      logic       mst;
      net = r[13];
      mst = r[15] & net;
      case (r[1:0])
         2'h2:    sel = r[3] ? 7'h5c : (r[2] ? 7'h5b : 7'h5a);
         2'h3:    sel = r[15:9];
         default: sel = {1'b0, r[7:2]};
      endcase
      return {sel, r[8] | r[10], r[9] & r[11] & r[12], net, r[14], mst,
              r[4] | !(net & !mst), r[5] | r[6], r[7] & r[12], r[11] & r[14] & mst};
   endfunction

   task automatic cmp_val(input string what, input logic [8:0] exp, input logic [8:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_flag(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic put(input logic [15:0] c);
      want <= c;
      @(negedge clk);
   endtask

   // Window spans more than one full blink period, so a blinking lamp shows both levels
   task automatic observe(output logic [8:0] pat);
      logic [3:0] a;
      logic [3:0] o;
      a = 4'hf;
      o = 4'h0;
      repeat (2 * HALF + 2) begin
         @(negedge clk);
         a = a & {pw, er, rd, ba};
         o = o | {pw, er, rd, ba};
      end
      pat[8] = ioz;
      for (int i = 0; i < 4; i++)
         pat[2*i +: 2] = (a[i] === 1'b1) ? ON : (o[i] === 1'b0) ? OFF :
                         (a[i] === 1'b0 && o[i] === 1'b1) ? BL : 2'h3;
   endtask

   task automatic check_case(input logic [15:0] c);
      logic [8:0] pat;
      put(c);
      repeat (2) @(negedge clk);
      observe(pat);
      if (c[15:9] <= 7'h3f) exp_addr = c[14:9];
      cmp_val("lamps", exp_pat(c), pat); // lamp decode
      cmp_flag("config mode", c[15:9] >= 7'h5a && c[15:9] <= 7'h5c, cfgm); // selector range
      cmp_val("node address", {3'h0, exp_addr}, {3'h0, node}); // selector address
   endtask

   task automatic wait_pulse(output int n);
      n = 0;
      for (int i = 1; i <= 60 && n == 0; i++) begin
         @(negedge clk);
         if (srst_req === 1'b1) n = i;
      end
   endtask

   task automatic end_sim();
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      repeat (5) @(negedge clk);
      cmp_val("reset outputs", 9'h000, {2'h0, pw, er, rd, ba, srst_req, ioz, cfgm});
      cmp_val("reset address", 9'h000, {3'h0, node});
      repeat (7) @(negedge clk);
      srst <= 1'b0;
      foreach (corner[i]) check_case(corner[i]);
      repeat (40) begin
         seed = nxt(seed);
         check_case(mix(seed));
      end
      // Timed restart: first pulse after the full span, then again every span
      foreach (fault[i]) begin
         put(16'h0b5c);
         repeat (3) @(negedge clk);
         put(fault[i]);
         wait_pulse(idx);
         cmp_val("restart delay", 9'(SRC), 9'(idx)); // timed restart
         wait_pulse(idx);
         cmp_val("restart period", 9'(SRC), 9'(idx)); // repeated restart
      end
      // A one-cycle gap in the fault must start the span again
      put(16'h0b5c);
      repeat (3) @(negedge clk);
      put(16'h0b5e);
      repeat (SRC - 32'h6) @(negedge clk);
      put(16'h0b5c);
      put(16'h0b5e);
      wait_pulse(idx);
      cmp_val("restart after gap", 9'(SRC), 9'(idx)); // count restart
      // Module failure hold, with a second report inside the hold that must be ignored
      put(16'h0b5c);
      repeat (3) @(negedge clk);
      fail_req <= 1'b1;
      @(negedge clk);
      fail_req <= 1'b0;
      // Restart cycle shows power only; the normal pattern returns one cycle later
      for (int i = 1; i <= MEC + 2; i++) begin
         @(negedge clk);
         if (i == 4) fail_req <= 1'b1;
         if (i == 5) fail_req <= 1'b0;
         cmp_val("module fail", (i <= MEC) ? 9'h018 : (i == MEC + 1) ? 9'h011 : 9'h016,
                 {4'h0, pw, er, rd, ba, srst_req}); // hold
      end
      end_sim();
   end

   // Watchdog well beyond the roughly nine hundred cycles the sequence needs
   initial begin
      repeat (8000) @(posedge clk);
      n_mismatch++;
      end_sim();
   end
endmodule
